// >>> rtl/btu_branch_target_unit.sv
`timescale 1ns/1ns
`default_nettype none
module btu_branch_target_unit
	import btu_pkg::*;
(
	// Core
	input wire logic CLK,
	input wire logic RESET,
	// Decoder request
	input wire logic REQ_VALID,
	input wire logic [2:0] OP,
	input wire logic [15:0] PC_INC,
	input wire logic [7:0] OPCODE,
	input wire logic [7:0] OPERAND_LO,
	input wire logic [7:0] OPERAND_HI,
	// Result
	output logic PC_LOAD,
	output logic [15:0] PC_NEW,
	output logic RET_PUSH,
	output logic [15:0] RET_ADDR
);
	btu_calc_if cif();
	logic pc_load_reg, pc_load_next;
	logic ret_push_reg, ret_push_next;
	logic [15:0] pc_new_reg, pc_new_next;
	logic [15:0] ret_addr_reg, ret_addr_next;

	// ****************
	// Decode
	// ****************
	assign cif.op = REQ_VALID ? btu_op_e'(OP) : BTU_NONE;
	assign cif.pc_inc = PC_INC;
	assign cif.opcode = OPCODE;
	assign cif.operand_lo = OPERAND_LO;
	assign cif.operand_hi = OPERAND_HI;

	btu_calc u_calc (
		.cif(cif)
	);

	// ****************
	// Result registers
	// ****************
	always_comb begin
		pc_load_next = cif.is_branch;
		pc_new_next = cif.is_branch ? cif.target : pc_new_reg;
		ret_push_next = cif.is_call;
		ret_addr_next = cif.is_call ? PC_INC : ret_addr_reg;
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			pc_load_reg <= 1'b0;
			ret_push_reg <= 1'b0;
			pc_new_reg <= PC_RESET;
			ret_addr_reg <= PC_RESET;
		end else begin
			pc_load_reg <= pc_load_next;
			ret_push_reg <= ret_push_next;
			pc_new_reg <= pc_new_next;
			ret_addr_reg <= ret_addr_next;
		end
	end

	assign PC_LOAD = pc_load_reg;
	assign PC_NEW = pc_new_reg;
	assign RET_PUSH = ret_push_reg;
	assign RET_ADDR = ret_addr_reg;

	// ****************
	// Checks
	// ****************

	// Request classes as the decoder presents them
	function automatic logic is_rel_op(input logic [2:0] code);
		is_rel_op = (code == BTU_SHORT_RELATIVE_JUMP);
	endfunction

	function automatic logic is_page_op(input logic [2:0] code);
		is_page_op = (code == BTU_PAGE_JUMP) || (code == BTU_PAGE_CALL);
	endfunction

	function automatic logic is_long_op(input logic [2:0] code);
		is_long_op = (code == BTU_LONG_JUMP) || (code == BTU_LONG_CALL);
	endfunction

	function automatic logic is_call_op(input logic [2:0] code);
		is_call_op = (code == BTU_PAGE_CALL) || (code == BTU_LONG_CALL);
	endfunction

	// ****************
	// Check helpers
	// ****************
	// Requests seen at the last edge, cleared by reset so no false pulse follows it
	logic chk_taken, chk_call;
	logic chk_taken_reg, chk_taken_next;
	logic chk_call_reg, chk_call_next;

	assign chk_taken = REQ_VALID && (is_rel_op(OP) || is_page_op(OP) || is_long_op(OP));
	assign chk_call = REQ_VALID && is_call_op(OP);

	always_comb begin
		chk_taken_next = chk_taken;
		chk_call_next = chk_call;
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			chk_taken_reg <= 1'b0;
			chk_call_reg <= 1'b0;
		end else begin
			chk_taken_reg <= chk_taken_next;
			chk_call_reg <= chk_call_next;
		end
	end

	// ****************
	// Request and result sequences
	// ****************
	sequence seq_rel_req;
		REQ_VALID && is_rel_op(OP);
	endsequence

	sequence seq_page_req;
		REQ_VALID && is_page_op(OP);
	endsequence

	// Page branch whose incremented PC has just crossed into a new page
	sequence seq_page_edge_req;
		REQ_VALID && is_page_op(OP) && (PC_INC[PAGE_W-1:0] == '0);
	endsequence

	sequence seq_long_req;
		REQ_VALID && is_long_op(OP);
	endsequence

	sequence seq_call_req;
		chk_call;
	endsequence

	sequence seq_no_call;
		!chk_call;
	endsequence

	sequence seq_taken;
		chk_taken;
	endsequence

	sequence seq_loaded;
		PC_LOAD;
	endsequence

	sequence seq_pushed;
		RET_PUSH && PC_LOAD;
	endsequence

	// ****************
	// Assertions
	// ****************
	AST_REL_TARGET: assert property (@(posedge CLK) disable iff (RESET)
		seq_rel_req |=> (PC_LOAD &&
		$signed(16'(PC_NEW - $past(PC_INC))) == $signed($past(OPERAND_LO))))
		else $error("relative target wrong");

	AST_REL_RANGE: assert property (@(posedge CLK) disable iff (RESET)
		seq_rel_req |=> ($signed(16'(PC_NEW - $past(PC_INC))) >= REL_MIN &&
		$signed(16'(PC_NEW - $past(PC_INC))) <= REL_MAX))
		else $error("relative target out of range");

	AST_PAGE_FIELD: assert property (@(posedge CLK) disable iff (RESET)
		seq_page_req |=> (PC_LOAD &&
		PC_NEW[PAGE_W-1:0] == {$past(OPCODE[PAGE_HI_LSB +: PAGE_HI_W]), $past(OPERAND_LO)}))
		else $error("page field wrong");

	AST_PAGE_KEEP: assert property (@(posedge CLK) disable iff (RESET)
		seq_page_req |=> (PC_LOAD && PC_NEW[PC_W-1:PAGE_W] == $past(PC_INC[PC_W-1:PAGE_W])))
		else $error("page bits changed");

	AST_PAGE_NEXT: assert property (@(posedge CLK) disable iff (RESET)
		seq_page_edge_req |=> (PC_NEW[PC_W-1:PAGE_W] == $past(PC_INC[PC_W-1:PAGE_W])))
		else $error("page not from incremented pc");

	AST_LONG: assert property (@(posedge CLK) disable iff (RESET)
		seq_long_req |=> (PC_LOAD && PC_NEW == {$past(OPERAND_HI), $past(OPERAND_LO)}))
		else $error("long target wrong");

	AST_HOLD: assert property (@(posedge CLK) disable iff (RESET)
		!PC_LOAD |-> (PC_NEW == $past(PC_NEW)))
		else $error("target moved without load");

	AST_LOAD_PULSE: assert property (@(posedge CLK) disable iff (RESET)
		PC_LOAD == chk_taken_reg)
		else $error("load pulse not one cycle after request");

	AST_BACK_TO_BACK: assert property (@(posedge CLK) disable iff (RESET)
		seq_taken ##1 seq_taken |-> seq_loaded ##1 seq_loaded)
		else $error("back to back requests lost a load");

	AST_RESET_QUIET: assert property (@(posedge CLK)
		RESET |-> (!PC_LOAD && !RET_PUSH && PC_NEW == PC_RESET && RET_ADDR == PC_RESET))
		else $error("outputs not cleared in reset");

	AST_CALL_RET: assert property (@(posedge CLK) disable iff (RESET)
		seq_call_req |=> (RET_PUSH && PC_LOAD && RET_ADDR == $past(PC_INC)))
		else $error("return address wrong");

	AST_JUMP_NOPUSH: assert property (@(posedge CLK) disable iff (RESET)
		seq_no_call |=> !RET_PUSH)
		else $error("push on non-call");

	AST_PUSH_PULSE: assert property (@(posedge CLK) disable iff (RESET)
		RET_PUSH == chk_call_reg)
		else $error("push pulse not one cycle after call");

	AST_PUSH_WITH_LOAD: assert property (@(posedge CLK) disable iff (RESET)
		RET_PUSH |-> PC_LOAD)
		else $error("push without load");

	AST_CALL_THEN_BRANCH: assert property (@(posedge CLK) disable iff (RESET)
		seq_call_req ##1 seq_taken |-> seq_pushed ##1 seq_loaded)
		else $error("call followed by branch lost a step");

	AST_RET_HOLD: assert property (@(posedge CLK) disable iff (RESET)
		!RET_PUSH |-> (RET_ADDR == $past(RET_ADDR)))
		else $error("return address moved without push");
endmodule
`default_nettype wire

// >>> rtl/btu_pkg.sv
package btu_pkg;
	localparam int PC_W = 16;
	localparam int OFS_W = 8;
	localparam int PAGE_W = 11;
	localparam int PAGE_HI_W = 3;
	localparam int PAGE_HI_LSB = 5;
	localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
	localparam int REL_MIN = -128;
	localparam int REL_MAX = 127;
	typedef enum logic [2:0] {
		BTU_NONE = 3'b000,
		BTU_SHORT_RELATIVE_JUMP = 3'b001,
		BTU_PAGE_JUMP = 3'b010,
		BTU_PAGE_CALL = 3'b011,
		BTU_LONG_JUMP = 3'b100,
		BTU_LONG_CALL = 3'b101
	} btu_op_e;
endpackage

// >>> rtl/btu_calc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface btu_calc_if;
	import btu_pkg::*;
	btu_op_e op;
	logic [15:0] pc_inc;
	logic [7:0] opcode;
	logic [7:0] operand_lo;
	logic [7:0] operand_hi;
	logic [15:0] target;
	logic is_call;
	logic is_branch;
	modport top (output op, pc_inc, opcode, operand_lo, operand_hi, input target, is_call, is_branch);
	modport calc (input op, pc_inc, opcode, operand_lo, operand_hi, output target, is_call, is_branch);
endinterface
`default_nettype wire

// >>> rtl/btu_calc.sv
`timescale 1ns/1ns
`default_nettype none
module btu_calc
	import btu_pkg::*;
(
	btu_calc_if.calc cif
);
	// ****************
	// Page field
	// ****************
	function automatic logic [PAGE_W-1:0] page_field(input logic [7:0] opc, input logic [7:0] lo);
		page_field = {opc[PAGE_HI_LSB +: PAGE_HI_W], lo};
	endfunction

	always_comb begin
		cif.target = cif.pc_inc;
		cif.is_call = 1'b0;
		cif.is_branch = 1'b1;
		unique case (cif.op)
			BTU_SHORT_RELATIVE_JUMP: begin
				cif.target = cif.pc_inc + {{(PC_W-OFS_W){cif.operand_lo[7]}}, cif.operand_lo};
			end
			BTU_PAGE_JUMP, BTU_PAGE_CALL: begin
				cif.target = {cif.pc_inc[PC_W-1:PAGE_W], page_field(cif.opcode, cif.operand_lo)};
				cif.is_call = (cif.op == BTU_PAGE_CALL);
			end
			BTU_LONG_JUMP, BTU_LONG_CALL: begin
				cif.target = {cif.operand_hi, cif.operand_lo};
				cif.is_call = (cif.op == BTU_LONG_CALL);
			end
			default: begin
				cif.is_branch = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

// >>> tb/btu_req_model.sv
`timescale 1ns/1ns
`default_nettype none
module btu_req_model (
	// Core
	input wire logic clk,
	// Request to the block
	output logic req_valid,
	output logic [2:0] op,
	output logic [15:0] pc_inc,
	output logic [23:0] bytes
);
	logic [32:0] exp_q[$];
	logic [15:0] t;
	initial {req_valid, op, pc_inc, bytes} = '0;
	task automatic send(input logic v, input logic [2:0] o, input logic [15:0] pc, input logic [23:0] b);
		@(negedge clk);
		{req_valid, op, pc_inc, bytes} = {v, o, pc, b};
		case (o)
			3'h1: t = pc + {{8{b[7]}}, b[7:0]};
			3'h2, 3'h3: t = {pc[15:11], b[23:21], b[7:0]};
			default: t = b[15:0];
		endcase
		if (v && o inside {[3'h1:3'h5]})
			exp_q.push_back({o == 3'h3 || o == 3'h5, t, pc});
	endtask
	// Released lines flip so stale values cannot pass
	task automatic idle();
		@(negedge clk);
		{req_valid, op, pc_inc, bytes} = ~{1'b1, op, pc_inc, bytes};
	endtask
endmodule
`default_nettype wire

// >>> tb/test_branch_target_unit.sv
`timescale 1ns/1ns
`default_nettype none
module test_branch_target_unit;
	logic CLK, RESET, req_valid, pc_load, ret_push;
	logic [2:0] op;
	logic [15:0] pc_inc, pc_new, ret_addr;
	logic [23:0] bytes;
	logic [32:0] e;
	int err_count = 0;
	int samples_checked = 0;
	btu_req_model m_u (.clk(CLK), .req_valid(req_valid), .op(op), .pc_inc(pc_inc), .bytes(bytes));
	btu_branch_target_unit dut_u (.CLK(CLK), .RESET(RESET), .REQ_VALID(req_valid), .OP(op),
		.PC_INC(pc_inc), .OPCODE(bytes[23:16]), .OPERAND_LO(bytes[7:0]), .OPERAND_HI(bytes[15:8]),
		.PC_LOAD(pc_load), .PC_NEW(pc_new), .RET_PUSH(ret_push), .RET_ADDR(ret_addr));
	task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	// Monitor: each load pulse consumes the oldest expectation
	always @(posedge CLK) begin
		#1;
		if (pc_load !== 1'b0 && m_u.exp_q.size() == 0)
			check("stray load", 16'(pc_load), 16'h0);
		else if (pc_load !== 1'b0) begin
			e = m_u.exp_q.pop_front();
			check("pc_new", pc_new, e[31:16]);
			check("ret_push", 16'(ret_push), 16'(e[32]));
			if (e[32])
				check("ret_addr", ret_addr, e[15:0]);
		end else
			check("idle push", 16'(ret_push), 16'h0);
	end
	initial begin
		#20000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		RESET = 1'b1;
		void'($urandom(32'h8196ae97));
		repeat (4) @(negedge CLK);
		RESET = 1'b0;
		m_u.send(1'b1, 3'h1, 16'h1234, 24'h000080);
		m_u.send(1'b1, 3'h1, 16'h1234, 24'h00007f);
		m_u.send(1'b1, 3'h1, 16'h0005, 24'h0000f0);
		m_u.send(1'b1, 3'h1, 16'hfff0, 24'h00007f);
		m_u.send(1'b1, 3'h2, 16'h0800, 24'he0005a);
		m_u.send(1'b1, 3'h3, 16'hf7ff, 24'ha10033);
		m_u.send(1'b1, 3'h4, 16'h4321, 24'h00ffff);
		m_u.send(1'b1, 3'h5, 16'h1234, 24'h00abcd);
		m_u.send(1'b1, 3'h0, 16'h1111, 24'h123456);
		m_u.send(1'b1, 3'h6, 16'h2222, 24'h123456);
		m_u.send(1'b1, 3'h7, 16'h3333, 24'h123456);
		m_u.send(1'b0, 3'h5, 16'h4444, 24'h123456);
		m_u.idle();
		repeat (300) begin
			if ($urandom_range(0, 4) == 0)
				m_u.idle();
			m_u.send($urandom_range(0, 3) != 0, 3'($urandom), 16'($urandom), 24'($urandom));
		end
		repeat (3) m_u.idle();
		check("pending", 16'(m_u.exp_q.size()), 16'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
